/* design/secondary_configuration_pkg.sv */
// Package with offsets, field positions, reset values and timing for the secondary configuration register.
package secondary_configuration_pkg;
   localparam logic [7:0] SECONDARY_CONFIGURATION_ADDR = 8'h14;
   localparam logic [7:0] SECOND_CONFIGURATION_ADDR = 8'h15;
   localparam logic [7:0] BOOSTER_CONFIGURATION_ADDR = 8'h16;
   localparam logic [15:0] SECONDARY_CONFIGURATION_RESET = 16'hC111;
   localparam logic [15:0] WRITE_MASK = 16'hFFF0;
   localparam int CLAMP_HI = 15;
   localparam int CLAMP_LO = 14;
   localparam int OCP_BIT = 13;
   localparam int UV_BIT = 12;
   localparam int DESAT_BIT = 11;
   localparam int TIMEOUT_BIT = 10;
   localparam int PSUP_BIT = 9;
   localparam int DCLAMP_BIT = 8;
   localparam int IO2_HI = 7;
   localparam int IO2_LO = 6;
   localparam int UNLOCK_BIT = 5;
   localparam int VBE_BIT = 4;
   localparam int LMI_BIT = 1;
   localparam int PARITY_BIT = 0;
   localparam logic [1:0] CLAMP_LOW = 2'h0;
   localparam logic [1:0] CLAMP_HIGH = 2'h1;
   localparam logic [1:0] CLAMP_SAFE = 2'h2;
   localparam logic [1:0] CLAMP_REGULAR = 2'h3;
   localparam logic [1:0] IO2_INPUT = 2'h0;
   localparam logic [1:0] IO2_FORWARD = 2'h1;
   localparam int CLK_HZ = 25000000;
   localparam int TIMEOUT_REGULAR_MS = 15;
   localparam int TIMEOUT_LONG_MS = 60;
   localparam longint TIMEOUT_REGULAR_CYCLES = longint'(CLK_HZ) * TIMEOUT_REGULAR_MS / 1000;
   localparam longint TIMEOUT_LONG_CYCLES = longint'(CLK_HZ) * TIMEOUT_LONG_MS / 1000;
endpackage : secondary_configuration_pkg

/* design/two_stage_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module two_stage_sync
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic async_in,
   output logic sync_out
);
   logic stage_reg;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage_reg <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         stage_reg <= async_in;
         sync_out <= stage_reg;
      end
   end
endmodule : two_stage_sync

/* design/secondary_config_register.sv */
// Secondary configuration register with its control outputs and advanced write gating.
// Function
// - The two-bit clamp field drives the inhibit pin low, high, in safe turn-off only, or in any turn-off.
// - The overcurrent level bit selects the first threshold at zero and the second at one.
// - The secondary undervoltage level bit selects the first lockout threshold at zero and the second at one.
// - The desaturation level bit selects the first detection threshold at zero and the second at one.
// - The time-out length bit selects about 15 ms at zero and about 60 ms at one for verification mode.
// - The pulse suppressor enable bit switches the internal pulse suppressor on and off.
// - With desaturation clamping enabled the sense pin is tied to ground while the PWM command is off.
// - The second I/O pin mode makes that pin an input at 00 and a forwarder of the first pin at 01.
// - While the unlock bit is clear, writes to the second configuration and booster registers are discarded.
// - The unlock bit clears itself whenever the configuration operating mode is left.
// - The base-emitter compensation bit applies compensation to the turn-off, turn-on and weak turn-on plateaus.
// - The last-message-invalid bit reads one after a discarded message and zero after a processed one.
`timescale 1ns/1ps
module secondary_config_register
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic msg_done,
   input wire logic msg_discarded,
   input wire logic configuration_operating_mode,
   input wire logic turn_off_regular,
   input wire logic turn_off_safe,
   input wire logic pwm_on,
   input wire logic first_digital_io_pin,
   input wire logic second_digital_io_pin_in,
   output logic [15:0] reg_rdata,
   output logic advanced_write_enable,
   output logic active_clamp_inhibit_pin,
   output logic overcurrent_level_select,
   output logic secondary_undervoltage_level_select,
   output logic desaturation_level_select,
   output logic [31:0] verification_timeout_cycles,
   output logic pulse_suppressor_enable,
   output logic desaturation_clamp_active,
   output logic base_emitter_compensation_enable,
   output logic second_digital_io_pin_out,
   output logic second_digital_io_pin_oe_n,
   output logic second_digital_io_pin_value
);
   logic [15:0] config_reg;
   logic last_message_invalid_reg;
   logic mode_reg;
   logic io1_sync;
   logic io2_sync;
   logic cfg_write;
   logic adv_write;
   logic [15:0] read_word;

   function automatic logic [15:0] with_parity(input logic [15:0] w);
      logic [15:0] r;
      r = w;
      r[secondary_configuration_pkg::PARITY_BIT] = ~(^w[15:1]);
      return r;
   endfunction : with_parity

   two_stage_sync io1_sync_i (.clk(clk), .resetn(resetn), .async_in(first_digital_io_pin), .sync_out(io1_sync));
   two_stage_sync io2_sync_i (.clk(clk), .resetn(resetn), .async_in(second_digital_io_pin_in), .sync_out(io2_sync));

   assign cfg_write = reg_write && (reg_addr == secondary_configuration_pkg::SECONDARY_CONFIGURATION_ADDR);
   assign adv_write = reg_write && config_reg[secondary_configuration_pkg::UNLOCK_BIT]
      && ((reg_addr == secondary_configuration_pkg::SECOND_CONFIGURATION_ADDR)
      || (reg_addr == secondary_configuration_pkg::BOOSTER_CONFIGURATION_ADDR));

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         mode_reg <= 1'b0;
      else
         mode_reg <= configuration_operating_mode;
   end

   // Mode exit outranks a simultaneous write so the unlock bit cannot survive leaving the mode.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         config_reg <= secondary_configuration_pkg::SECONDARY_CONFIGURATION_RESET & secondary_configuration_pkg::WRITE_MASK;
      else
      begin
         if (cfg_write)
            config_reg <= reg_wdata & secondary_configuration_pkg::WRITE_MASK;
         if (mode_reg && !configuration_operating_mode)
            config_reg[secondary_configuration_pkg::UNLOCK_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         last_message_invalid_reg <= 1'b0;
      else if (msg_done)
         last_message_invalid_reg <= msg_discarded;
   end

   always_comb
   begin
      read_word = config_reg;
      read_word[secondary_configuration_pkg::LMI_BIT] = last_message_invalid_reg;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata <= 16'h0000;
         advanced_write_enable <= 1'b0;
      end
      else
      begin
         reg_rdata <= with_parity(read_word);
         advanced_write_enable <= adv_write;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         active_clamp_inhibit_pin <= 1'b0;
      else
      begin
         case (config_reg[secondary_configuration_pkg::CLAMP_HI:secondary_configuration_pkg::CLAMP_LO])
            secondary_configuration_pkg::CLAMP_LOW: active_clamp_inhibit_pin <= 1'b0;
            secondary_configuration_pkg::CLAMP_HIGH: active_clamp_inhibit_pin <= 1'b1;
            secondary_configuration_pkg::CLAMP_SAFE: active_clamp_inhibit_pin <= turn_off_safe;
            secondary_configuration_pkg::CLAMP_REGULAR: active_clamp_inhibit_pin <= turn_off_safe || turn_off_regular;
            default: active_clamp_inhibit_pin <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         overcurrent_level_select <= 1'b0;
         secondary_undervoltage_level_select <= 1'b0;
         desaturation_level_select <= 1'b0;
         verification_timeout_cycles <= 32'h00000000;
         pulse_suppressor_enable <= 1'b0;
         desaturation_clamp_active <= 1'b0;
         base_emitter_compensation_enable <= 1'b0;
      end
      else
      begin
         overcurrent_level_select <= config_reg[secondary_configuration_pkg::OCP_BIT];
         secondary_undervoltage_level_select <= config_reg[secondary_configuration_pkg::UV_BIT];
         desaturation_level_select <= config_reg[secondary_configuration_pkg::DESAT_BIT];
         verification_timeout_cycles <= config_reg[secondary_configuration_pkg::TIMEOUT_BIT] ?
            32'(secondary_configuration_pkg::TIMEOUT_LONG_CYCLES) : 32'(secondary_configuration_pkg::TIMEOUT_REGULAR_CYCLES);
         pulse_suppressor_enable <= config_reg[secondary_configuration_pkg::PSUP_BIT];
         desaturation_clamp_active <= config_reg[secondary_configuration_pkg::DCLAMP_BIT] && !pwm_on;
         base_emitter_compensation_enable <= config_reg[secondary_configuration_pkg::VBE_BIT];
      end
   end

   // Reserved codes leave the pin as an input, the safe choice when the intent is unknown.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         second_digital_io_pin_out <= 1'b0;
         second_digital_io_pin_oe_n <= 1'b1;
         second_digital_io_pin_value <= 1'b0;
      end
      else
      begin
         second_digital_io_pin_out <= io1_sync;
         second_digital_io_pin_oe_n <=
            config_reg[secondary_configuration_pkg::IO2_HI:secondary_configuration_pkg::IO2_LO] != secondary_configuration_pkg::IO2_FORWARD;
         second_digital_io_pin_value <= io2_sync;
      end
   end

   sequence leave_mode_s;
      $fell(configuration_operating_mode);
   endsequence

   sequence adv_request_s;
      reg_write && config_reg[secondary_configuration_pkg::UNLOCK_BIT] && ((reg_addr == secondary_configuration_pkg::SECOND_CONFIGURATION_ADDR)
         || (reg_addr == secondary_configuration_pkg::BOOSTER_CONFIGURATION_ADDR));
   endsequence

   // The sampled reset in an antecedent skips the releasing edge, where outputs still hold their reset values.

   clamp_low_a: assert property (@(posedge clk) disable iff (!resetn)
      config_reg[secondary_configuration_pkg::CLAMP_HI:secondary_configuration_pkg::CLAMP_LO] == secondary_configuration_pkg::CLAMP_LOW |=> !active_clamp_inhibit_pin)
      else $error("Clamp pin not low.");
   clamp_high_a: assert property (@(posedge clk) disable iff (!resetn)
      config_reg[secondary_configuration_pkg::CLAMP_HI:secondary_configuration_pkg::CLAMP_LO] == secondary_configuration_pkg::CLAMP_HIGH |=> active_clamp_inhibit_pin)
      else $error("Clamp pin not high.");
   ocp_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      ##1 overcurrent_level_select == $past(config_reg[secondary_configuration_pkg::OCP_BIT]))
      else $error("Overcurrent select mismatch.");
   timeout_len_a: assert property (@(posedge clk) disable iff (!resetn)
      config_reg[secondary_configuration_pkg::TIMEOUT_BIT] |=> verification_timeout_cycles == 32'(secondary_configuration_pkg::TIMEOUT_LONG_CYCLES))
      else $error("Long time-out wrong.");
   dclamp_pwm_a: assert property (@(posedge clk) disable iff (!resetn)
      pwm_on |=> !desaturation_clamp_active)
      else $error("Desat clamp active while PWM on.");
   io2_dir_a: assert property (@(posedge clk) disable iff (!resetn)
      config_reg[secondary_configuration_pkg::IO2_HI:secondary_configuration_pkg::IO2_LO] != secondary_configuration_pkg::IO2_FORWARD |=> second_digital_io_pin_oe_n)
      else $error("Second I/O pin driven outside forward mode.");
   locked_write_a: assert property (@(posedge clk) disable iff (!resetn)
      !config_reg[secondary_configuration_pkg::UNLOCK_BIT] |=> !advanced_write_enable)
      else $error("Advanced write while locked.");
   unlock_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      leave_mode_s |-> ##1 !config_reg[secondary_configuration_pkg::UNLOCK_BIT])
      else $error("Unlock bit survived mode exit.");
   lmi_track_a: assert property (@(posedge clk) disable iff (!resetn)
      msg_done |=> last_message_invalid_reg == $past(msg_discarded))
      else $error("Last message flag wrong.");
   odd_parity_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> (^reg_rdata) && reg_rdata[3:2] == 2'h0)
      else $error("Read word not odd parity.");
   clamp_safe_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn && config_reg[secondary_configuration_pkg::CLAMP_HI:secondary_configuration_pkg::CLAMP_LO] == secondary_configuration_pkg::CLAMP_SAFE
         |=> active_clamp_inhibit_pin == $past(turn_off_safe))
      else $error("Clamp pin not following safe turn-off.");
   clamp_any_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn && config_reg[secondary_configuration_pkg::CLAMP_HI:secondary_configuration_pkg::CLAMP_LO] == secondary_configuration_pkg::CLAMP_REGULAR
         |=> active_clamp_inhibit_pin == $past(turn_off_safe || turn_off_regular))
      else $error("Clamp pin not following turn-off.");
   uv_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> secondary_undervoltage_level_select == $past(config_reg[secondary_configuration_pkg::UV_BIT]))
      else $error("Undervoltage select mismatch.");
   desat_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> desaturation_level_select == $past(config_reg[secondary_configuration_pkg::DESAT_BIT]))
      else $error("Desaturation select mismatch.");
   timeout_short_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn && !config_reg[secondary_configuration_pkg::TIMEOUT_BIT]
         |=> verification_timeout_cycles == 32'(secondary_configuration_pkg::TIMEOUT_REGULAR_CYCLES))
      else $error("Regular time-out wrong.");
   psup_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> pulse_suppressor_enable == $past(config_reg[secondary_configuration_pkg::PSUP_BIT]))
      else $error("Pulse suppressor enable mismatch.");
   io2_forward_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn && config_reg[secondary_configuration_pkg::IO2_HI:secondary_configuration_pkg::IO2_LO] == secondary_configuration_pkg::IO2_FORWARD
         |=> !second_digital_io_pin_oe_n && second_digital_io_pin_out == $past(io1_sync))
      else $error("Second I/O pin not forwarding.");
   unlocked_write_a: assert property (@(posedge clk) disable iff (!resetn)
      adv_request_s |=> advanced_write_enable)
      else $error("Unlocked advanced write dropped.");
   vbe_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> base_emitter_compensation_enable == $past(config_reg[secondary_configuration_pkg::VBE_BIT]))
      else $error("Compensation enable mismatch.");
endmodule : secondary_config_register

/* test/secondary_configuration_host_model.sv */
// Host-side model that issues register writes and message completions.
`timescale 1ns/1ps
module secondary_configuration_host_model
(
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_write,
   output logic msg_done,
   output logic msg_discarded
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      msg_done = 1'b0;
      msg_discarded = 1'b0;
   end

   // The data bus shows the inverse after release so a stale value is never read as a hit.
   task write_word(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask : write_word

   task end_message(input logic bad);
      @(posedge clk);
      msg_done <= 1'b1;
      msg_discarded <= bad;
      @(posedge clk);
      msg_done <= 1'b0;
      msg_discarded <= ~bad;
   endtask : end_message
endmodule : secondary_configuration_host_model

/* test/test_secondary_config_register.sv */
// Self-checking testbench for the secondary configuration register.
`timescale 1ns/1ps
module test_secondary_config_register;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic mode = 1'b1, off_reg = 1'b0, off_safe = 1'b0, pwm = 1'b0, io1 = 1'b0, io2_in = 1'b0;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic wr, mdone, mbad, awe, clamp, ocp, uv, ds, psup, dclamp, vbe, io2_out, io2_oe_n, io2_val, e1;
   logic [31:0] tmo;
   int n_fail = 0;
   int check_count = 0;
   int aw_count = 0;
   int aw_base = 0;
   // Each row holds a written word in the upper half and the word it must read back below.
   logic [31:0] rows [5] = '{32'h0000_0001, 32'hFFFF_FFF1, 32'h5A5A_5A51, 32'h2C8F_2C81, 32'hA5B6_A5B0};

   always #20 clk = ~clk;
   always @(posedge clk) if (awe === 1'b1) aw_count <= aw_count + 1;

   secondary_configuration_host_model secondary_configuration_host_model_i (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
      .msg_done(mdone), .msg_discarded(mbad));
   secondary_config_register secondary_config_register_i (.clk(clk), .resetn(resetn), .reg_addr(addr),
      .reg_wdata(wdata), .reg_write(wr), .msg_done(mdone), .msg_discarded(mbad),
      .configuration_operating_mode(mode), .turn_off_regular(off_reg), .turn_off_safe(off_safe), .pwm_on(pwm),
      .first_digital_io_pin(io1), .second_digital_io_pin_in(io2_in), .reg_rdata(rdata),
      .advanced_write_enable(awe), .active_clamp_inhibit_pin(clamp), .overcurrent_level_select(ocp),
      .secondary_undervoltage_level_select(uv), .desaturation_level_select(ds), .verification_timeout_cycles(tmo),
      .pulse_suppressor_enable(psup), .desaturation_clamp_active(dclamp), .base_emitter_compensation_enable(vbe),
      .second_digital_io_pin_out(io2_out), .second_digital_io_pin_oe_n(io2_oe_n),
      .second_digital_io_pin_value(io2_val));

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      secondary_configuration_host_model_i.write_word(a, d);
      settle(2);
   endtask : wr_reg

   task final_report;
      if (n_fail == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   // A hung design cannot keep the run alive past this bound.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end

   initial
   begin
      settle(4);
      check("oe_n_in_reset", 32'h1, io2_oe_n);
      @(posedge clk) resetn <= 1'b1;
      settle(2);
      check("reset_word", 32'hC111, rdata);
      check("reset_dclamp", 32'h1, dclamp);
      foreach (rows[i])
      begin
         wr_reg(secondary_configuration_pkg::SECONDARY_CONFIGURATION_ADDR, rows[i][31:16]);
         check("read_word", rows[i][15:0], rdata);
         check("ocp_level", rows[i][29], ocp);
         check("uv_level", rows[i][28], uv);
         check("desat_level", rows[i][27], ds);
         check("timeout", rows[i][26] ? 32'(secondary_configuration_pkg::TIMEOUT_LONG_CYCLES)
            : 32'(secondary_configuration_pkg::TIMEOUT_REGULAR_CYCLES), tmo);
         check("pulse_supp", rows[i][25], psup);
         check("dclamp", rows[i][24], dclamp);
         check("vbe_comp", rows[i][20], vbe);
      end
      for (int c = 0; c < 4; c++)
      begin
         wr_reg(8'h14, {c[1:0], 14'h0000});
         for (int k = 0; k < 4; k++)
         begin
            @(posedge clk);
            off_safe <= k[0];
            off_reg <= k[1];
            settle(3);
            e1 = (c == 0) ? 1'b0 : (c == 1) ? 1'b1 : (c == 2) ? k[0] : (k[0] | k[1]);
            check("clamp_pin", {31'h0, e1}, clamp);
         end
      end
      wr_reg(8'h14, 16'h0100);
      @(posedge clk) pwm <= 1'b1;
      settle(3);
      check("dclamp_pwm_on", 32'h0, dclamp);
      wr_reg(8'h14, 16'h0040);
      for (int k = 1; k >= 0; k--)
      begin
         @(posedge clk) io1 <= k[0];
         settle(5);
         check("io2_forward", k, io2_out);
         check("io2_drive", 32'h0, io2_oe_n);
      end
      wr_reg(8'h14, 16'h0080);
      @(posedge clk) io2_in <= 1'b1;
      settle(5);
      check("io2_reserved", 32'h1, io2_oe_n);
      check("io2_value", 32'h1, io2_val);
      wr_reg(8'h14, 16'h0000);
      aw_base = aw_count;
      wr_reg(8'h15, 16'h1234);
      check("locked_write", 32'h0, aw_count - aw_base);
      wr_reg(8'h14, 16'h0020);
      aw_base = aw_count;
      wr_reg(8'h16, 16'h1234);
      check("unlocked_write", 32'h1, aw_count - aw_base);
      @(posedge clk) mode <= 1'b0;
      settle(3);
      check("unlock_cleared", 32'h0, rdata[5]);
      aw_base = aw_count;
      wr_reg(8'h15, 16'h4321);
      check("relocked_write", 32'h0, aw_count - aw_base);
      secondary_configuration_host_model_i.end_message(1'b1);
      settle(2);
      check("msg_bad", 32'h1, rdata[1]);
      check("parity_bad", 32'h1, ^rdata);
      secondary_configuration_host_model_i.end_message(1'b0);
      settle(2);
      check("msg_good", 32'h0, rdata[1]);
      check("parity_good", 32'h1, ^rdata);
      @(posedge clk) resetn <= 1'b0;
      settle(2);
      check("timeout_in_reset", 32'h0, tmo);
      check("oe_n_reset_again", 32'h1, io2_oe_n);
      @(posedge clk) resetn <= 1'b1;
      settle(2);
      check("reset_word_again", 32'hC111, rdata);
      check("clamp_after_reset", 32'h1, clamp);
      check("vbe_after_reset", 32'h1, vbe);
      final_report();
   end
endmodule : test_secondary_config_register
